// File: design/ext_irq_detect.sv
// Per-pin synchroniser, falling-edge detector and edge flag for one input
`timescale 1ns/10ps
module ext_irq_detect
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic pinRaw,
    input wire logic edgeMode,
    input wire logic serviced,
    output logic pinLevel,
    output logic flag
);
    // Two-stage synchroniser; stage one feeds stage two only
    logic sync1_q, sync1_d;
    logic sync2_q, sync2_d;
    // Previous synchronised level for edge detection
    logic prev_q, prev_d;
    // Sticky edge or level flag
    logic flag_q, flag_d;
    logic hit;

    // Next-state logic
    always_comb
    begin
        sync1_d = pinRaw;
        sync2_d = sync1_q;
        prev_d = sync2_q;
        // Edge mode: high then low; level mode: low level follows pin
        hit = edgeMode ? (prev_q & ~sync2_q) : ~sync2_q;
        if (hit)
        begin
            // New event wins over a same-cycle service clear
            flag_d = 1'b1;
        end
        else if (serviced || !edgeMode)
        begin
            // Level mode flag tracks the pin; no latching beyond it
            flag_d = 1'b0;
        end
        else
        begin
            flag_d = flag_q;
        end
    end

    // Registers; idle pins read high so the pin stages reset to one, the flag to zero
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
            prev_q <= 1'b1;
            flag_q <= 1'b0;
        end
        else
        begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            prev_q <= prev_d;
            flag_q <= flag_d;
        end
    end

    assign pinLevel = sync2_q;
    assign flag = flag_q;
endmodule : ext_irq_detect

// File: design/timer_control_mode_regs.sv
// Timer control and mode special-function registers with run gating
`timescale 1ns/10ps
`include "timer_regs_consts.svh"
// Overview of operation
// - Control register at 88H, resets zero
// - Overflow pulse sets that timer's flag
// - Vectoring to timer service clears flag
// - Ext_irq1_pin type: one edge, zero level
// - Ext_irq0_pin type: one edge, zero level
// - Mode register at 89H, resets zero
// - Gate set needs pin high plus run
// - Counter select picks clock or pin events
// - Software keeps counter select zero in PWM
// - Mode field selects one of four modes
module timer_control_mode_regs
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrite,
    input wire logic [7:0] sfrWdata,
    input wire logic sfrRead,
    output logic [7:0] sfrRdata,
    input wire logic timer0Overflow,
    input wire logic timer1Overflow,
    input wire logic timer0Vector,
    input wire logic timer1Vector,
    input wire logic extIrq0Vector,
    input wire logic extIrq1Vector,
    input wire logic ext_irq0_pin,
    input wire logic ext_irq1_pin,
    input wire logic timer0CountPin,
    input wire logic timer1CountPin,
    output logic timer0CountEn,
    output logic timer1CountEn,
    output logic timer0CountSrcPin,
    output logic timer1CountSrcPin,
    output timer_regs_pkg::timer_mode_t timer0Mode,
    output timer_regs_pkg::timer_mode_t timer1Mode,
    output logic timer0CountTick,
    output logic timer1CountTick,
    output logic extIrq0Request,
    output logic extIrq1Request
);
    import timer_regs_pkg::*;

    // Control and mode register storage
    logic [7:0] ctrl_q, ctrl_d;
    logic [7:0] mode_q, mode_d;
    // Read data register
    logic [7:0] rdata_q, rdata_d;
    // Registered gated enables, sources and modes
    logic en0_q, en0_d, en1_q, en1_d;
    logic src0_q, src0_d, src1_q, src1_d;
    timer_mode_t m0_q, m0_d, m1_q, m1_d;
    logic tick0_q, tick0_d, tick1_q, tick1_d;
    logic req0_q, req0_d, req1_q, req1_d;
    // Synchronised count pins and previous samples
    logic c0s1_q, c0s2_q, c0p_q, c1s1_q, c1s2_q, c1p_q;
    // Edge detector outputs
    logic pin0Level, pin1Level, flag0, flag1;
    logic wrCtrl, wrMode;

    // Packed per-channel views, index 0 and 1 by interrupt number
    logic [1:0] irqPins, irqTypes, irqServed, pinLevels, irqFlags;

    // Gather channel inputs so both detectors share one loop
    assign irqPins = {ext_irq1_pin, ext_irq0_pin};
    assign irqTypes = {ctrl_q[`CTRL_X1_TYPE], ctrl_q[`CTRL_X0_TYPE]};
    assign irqServed = {extIrq1Vector, extIrq0Vector};

    // Interrupt pin detectors, trigger type from control bits
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++)
        begin : irqChan
            ext_irq_detect irq (
                .clock(clock),
                .rstn(rstn),
                .pinRaw(irqPins[ch]),
                .edgeMode(irqTypes[ch]),
                .serviced(irqServed[ch]),
                .pinLevel(pinLevels[ch]),
                .flag(irqFlags[ch])
            );
        end
    endgenerate

    // Named per-channel results used by the register logic
    assign pin0Level = pinLevels[0];
    assign pin1Level = pinLevels[1];
    assign flag0 = irqFlags[0];
    assign flag1 = irqFlags[1];

    // Register file next values and derived controls
    always_comb
    begin
        wrCtrl = sfrWrite && (sfrAddr == `CTRL_ADDR);
        wrMode = sfrWrite && (sfrAddr == `MODE_ADDR);
        ctrl_d = ctrl_q;
        mode_d = mode_q;
        if (wrCtrl)
        begin
            // Software may write every bit except the two interrupt flags
            ctrl_d = sfrWdata;
        end
        if (wrMode)
        begin
            // Counter-select kept zero in PWM by software
            mode_d = sfrWdata;
        end
        // Vector clear first so a same-cycle overflow wins
        if (timer0Vector)
        begin
            ctrl_d[`CTRL_T0_OVF] = 1'b0;
        end
        if (timer1Vector)
        begin
            ctrl_d[`CTRL_T1_OVF] = 1'b0;
        end
        if (timer0Overflow)
        begin
            ctrl_d[`CTRL_T0_OVF] = 1'b1;
        end
        if (timer1Overflow)
        begin
            ctrl_d[`CTRL_T1_OVF] = 1'b1;
        end
        // Interrupt flags are owned by the detectors
        ctrl_d[`CTRL_X0_FLAG] = flag0;
        ctrl_d[`CTRL_X1_FLAG] = flag1;
        // Gate needs pin high as well as run
        en0_d = ctrl_q[`CTRL_T0_RUN] &&
            (!mode_q[`MODE_T0_GATE] || pin0Level);
        en1_d = ctrl_q[`CTRL_T1_RUN] &&
            (!mode_q[`MODE_T1_GATE] || pin1Level);
        src0_d = mode_q[`MODE_T0_CSEL];
        src1_d = mode_q[`MODE_T1_CSEL];
        m0_d = timer_mode_t'(mode_q[`MODE_T0_HI:`MODE_T0_LO]);
        m1_d = timer_mode_t'(mode_q[`MODE_T1_HI:`MODE_T1_LO]);
        // Timer 1 in split mode is simply stopped
        if (m1_d == MODE_SPLIT)
        begin
            en1_d = 1'b0;
        end
        // Tick: every clock, or a pin falling edge
        tick0_d = en0_d && (src0_d ? (c0p_q && !c0s2_q) : 1'b1);
        tick1_d = en1_d && (src1_d ? (c1p_q && !c1s2_q) : 1'b1);
        req0_d = flag0;
        req1_d = flag1;
        // Reads answer one cycle later; unmapped reads return zero
        rdata_d = 8'h00;
        if (sfrRead && sfrAddr == `CTRL_ADDR)
        begin
            rdata_d = ctrl_q;
        end
        else if (sfrRead && sfrAddr == `MODE_ADDR)
        begin
            rdata_d = mode_q;
        end
    end

    // Registers, all reset to constants
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl_q <= `CTRL_RESET;
            mode_q <= `MODE_RESET;
            rdata_q <= 8'h00;
            en0_q <= 1'b0;
            en1_q <= 1'b0;
            src0_q <= 1'b0;
            src1_q <= 1'b0;
            m0_q <= MODE_VARWIDTH;
            m1_q <= MODE_VARWIDTH;
            tick0_q <= 1'b0;
            tick1_q <= 1'b0;
            req0_q <= 1'b0;
            req1_q <= 1'b0;
            c0s1_q <= 1'b1;
            c0s2_q <= 1'b1;
            c0p_q <= 1'b1;
            c1s1_q <= 1'b1;
            c1s2_q <= 1'b1;
            c1p_q <= 1'b1;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            mode_q <= mode_d;
            rdata_q <= rdata_d;
            en0_q <= en0_d;
            en1_q <= en1_d;
            src0_q <= src0_d;
            src1_q <= src1_d;
            m0_q <= m0_d;
            m1_q <= m1_d;
            tick0_q <= tick0_d;
            tick1_q <= tick1_d;
            req0_q <= req0_d;
            req1_q <= req1_d;
            // Count pins: two-flop sync, then one more for edges
            c0s1_q <= timer0CountPin;
            c0s2_q <= c0s1_q;
            c0p_q <= c0s2_q;
            c1s1_q <= timer1CountPin;
            c1s2_q <= c1s1_q;
            c1p_q <= c1s2_q;
        end
    end

    assign sfrRdata = rdata_q;
    assign timer0CountEn = en0_q;
    assign timer1CountEn = en1_q;
    assign timer0CountSrcPin = src0_q;
    assign timer1CountSrcPin = src1_q;
    assign timer0Mode = m0_q;
    assign timer1Mode = m1_q;
    assign timer0CountTick = tick0_q;
    assign timer1CountTick = tick1_q;
    assign extIrq0Request = req0_q;
    assign extIrq1Request = req1_q;
endmodule : timer_control_mode_regs

// File: design/timer_regs_consts.svh
// Offsets, bit positions and reset values of the timer regs
`ifndef TIMER_REGS_CONSTS_SVH
`define TIMER_REGS_CONSTS_SVH
`define CTRL_ADDR 8'h88
`define MODE_ADDR 8'h89
`define CTRL_RESET 8'h00
`define MODE_RESET 8'h00
`define CTRL_T1_OVF 7
`define CTRL_T1_RUN 6
`define CTRL_T0_OVF 5
`define CTRL_T0_RUN 4
`define CTRL_X1_FLAG 3
`define CTRL_X1_TYPE 2
`define CTRL_X0_FLAG 1
`define CTRL_X0_TYPE 0
`define MODE_T1_GATE 7
`define MODE_T1_CSEL 6
`define MODE_T1_HI 5
`define MODE_T1_LO 4
`define MODE_T0_GATE 3
`define MODE_T0_CSEL 2
`define MODE_T0_HI 1
`define MODE_T0_LO 0
`endif

// File: design/timer_regs_pkg.sv
// Types shared by the timer control and mode register files
package timer_regs_pkg;
    // Two-bit timer operating mode
    typedef enum logic [1:0] {
        MODE_VARWIDTH = 2'h0,
        MODE_RELOAD16 = 2'h1,
        MODE_RELOAD8 = 2'h2,
        MODE_SPLIT = 2'h3
    } timer_mode_t;
endpackage : timer_regs_pkg

// File: tb/timer_control_mode_regs_test.sv
// Self-checking bench for the timer control and mode registers
`timescale 1ns/10ps
module timer_control_mode_regs_test;
    import timer_regs_pkg::*;
    logic clock = 1'b0, rstn = 1'b0, sfrWrite = 1'b0, sfrRead = 1'b0;
    logic [7:0] sfrAddr = 8'h00, sfrWdata = 8'h00, sfrRdata;
    logic timer0Overflow = 1'b0, timer1Overflow = 1'b0;
    logic timer0Vector = 1'b0, timer1Vector = 1'b0;
    logic extIrq0Vector = 1'b0, extIrq1Vector = 1'b0;
    // Pins idle high so no request is pending out of reset
    logic ext_irq0_pin = 1'b1, ext_irq1_pin = 1'b1;
    logic timer0CountPin = 1'b1, timer1CountPin = 1'b1;
    logic timer0CountEn, timer1CountEn, timer0CountSrcPin, timer1CountSrcPin;
    logic timer0CountTick, timer1CountTick, extIrq0Request, extIrq1Request;
    timer_mode_t timer0Mode, timer1Mode;
    // Packed views of outputs so compares fit on one line
    logic [7:0] modeOuts, irqReqs;
    assign modeOuts = {4'h0, timer1Mode, timer0Mode};
    assign irqReqs = {6'h00, extIrq1Request, extIrq0Request};
    int failures = 0;
    int checkCount = 0;
    timer_control_mode_regs DUT (.clock, .rstn, .sfrAddr, .sfrWrite,
        .sfrWdata, .sfrRead, .sfrRdata, .timer0Overflow, .timer1Overflow,
        .timer0Vector, .timer1Vector, .extIrq0Vector, .extIrq1Vector,
        .ext_irq0_pin, .ext_irq1_pin, .timer0CountPin, .timer1CountPin,
        .timer0CountEn, .timer1CountEn, .timer0CountSrcPin,
        .timer1CountSrcPin, .timer0Mode, .timer1Mode, .timer0CountTick,
        .timer1CountTick, .extIrq0Request, .extIrq1Request);
    always #5 clock = ~clock;
    // Inputs always move 1 ns after the rising edge
    task step;
        @(posedge clock);
        #1;
    endtask : step
    task checkReg(input string name, input logic [7:0] exp,
        input logic [7:0] got);
        checkCount++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : checkReg
    task checkPin(input string name, input logic exp, input logic got);
        checkReg(name, {7'h00, exp}, {7'h00, got});
    endtask : checkPin
    // Extra edge after release keeps strobes from toggling in one step
    task wr(input logic [7:0] a, input logic [7:0] d);
        sfrAddr = a;
        sfrWdata = d;
        sfrWrite = 1'b1;
        step;
        sfrWrite = 1'b0;
        step;
    endtask : wr
    task rdCheck(input logic [7:0] a, input logic [7:0] exp, string name);
        sfrAddr = a;
        sfrRead = 1'b1;
        step;
        sfrRead = 1'b0;
        checkReg(name, exp, sfrRdata);
        step;
    endtask : rdCheck
    task reset_values;
        rdCheck(8'h88, 8'h00, "ctrl reset");
        rdCheck(8'h89, 8'h00, "mode reset");
        rdCheck(8'h8A, 8'h00, "unmapped read");
    endtask : reset_values
    task mode_select;
        logic [7:0] d;
        wr(8'h88, 8'h50);
        for (int m = 0; m < 4; m++)
        begin
            d = {2'b01, m[1:0], 2'b00, m[1:0]};
            wr(8'h89, d);
            checkReg("modes", {4'h0, d[5:4], d[1:0]}, modeOuts);
            checkPin("t1 enable", m != 3, timer1CountEn);
            checkPin("t1 source", 1'b1, timer1CountSrcPin);
            checkPin("t0 source", 1'b0, timer0CountSrcPin);
            checkPin("t0 tick", 1'b1, timer0CountTick);
            rdCheck(8'h89, d, "mode readback");
        end
        wr(8'h8B, 8'hFF);
        rdCheck(8'h89, 8'h73, "mode kept");
    endtask : mode_select
    task overflow_flags;
        wr(8'h88, 8'h00);
        timer0Overflow = 1'b1;
        timer1Overflow = 1'b1;
        step;
        timer0Overflow = 1'b0;
        timer1Overflow = 1'b0;
        rdCheck(8'h88, 8'hA0, "flags set");
        timer0Vector = 1'b1;
        step;
        timer0Vector = 1'b0;
        rdCheck(8'h88, 8'h80, "t0 cleared");
        timer1Vector = 1'b1;
        step;
        timer1Vector = 1'b0;
        rdCheck(8'h88, 8'h00, "t1 cleared");
    endtask : overflow_flags
    task run_gate;
        int ticks;
        int ticks1;
        ext_irq0_pin = 1'b0;
        wr(8'h89, 8'h08);
        wr(8'h88, 8'h10);
        checkPin("gated off", 1'b0, timer0CountEn);
        ext_irq0_pin = 1'b1;
        repeat (4) step;
        checkPin("gated on", 1'b1, timer0CountEn);
        wr(8'h88, 8'h00);
        checkPin("run off", 1'b0, timer0CountEn);
        // Both timers count pin events; one falling edge each
        wr(8'h89, 8'h44);
        wr(8'h88, 8'h50);
        ticks = 0;
        ticks1 = 0;
        {timer1CountPin, timer0CountPin} = 2'b00;
        repeat (6)
        begin
            step;
            ticks += timer0CountTick;
            ticks1 += timer1CountTick;
        end
        checkReg("pin ticks", 8'h01, 8'(ticks));
        checkReg("t1 pin ticks", 8'h01, 8'(ticks1));
    endtask : run_gate
    task ext_irqs;
        wr(8'h88, 8'h05);
        {ext_irq1_pin, ext_irq0_pin} = 2'b00;
        repeat (5) step;
        {ext_irq1_pin, ext_irq0_pin} = 2'b11;
        repeat (5) step;
        checkReg("edge held", 8'h03, irqReqs);
        rdCheck(8'h88, 8'h0F, "edge flags");
        {extIrq1Vector, extIrq0Vector} = 2'b11;
        step;
        {extIrq1Vector, extIrq0Vector} = 2'b00;
        repeat (2) step;
        checkReg("edge served", 8'h00, irqReqs);
        wr(8'h88, 8'h00);
        {ext_irq1_pin, ext_irq0_pin} = 2'b00;
        repeat (5) step;
        checkReg("level low", 8'h03, irqReqs);
        {ext_irq1_pin, ext_irq0_pin} = 2'b11;
        repeat (5) step;
        checkReg("level high", 8'h00, irqReqs);
    endtask : ext_irqs
    task report_and_stop;
        $display("checks %0d mismatches %0d", checkCount, failures);
        if (failures == 0 && checkCount > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    // Main sequence after five cycles of reset
    initial
    begin
        repeat (5) @(posedge clock);
        #1 rstn = 1'b1;
        reset_values;
        mode_select;
        overflow_flags;
        run_gate;
        ext_irqs;
        report_and_stop;
    end
    // Whole run needs some 93 cycles; over twenty times that means a hang
    initial
    begin
        repeat (2000) @(posedge clock);
        failures++;
        report_and_stop;
    end
endmodule : timer_control_mode_regs_test

// File: tb/timer_regs_checker_props.sv
// Port-level checks for the timer control and mode registers
`timescale 1ns/10ps
module timer_regs_checker
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrite,
    input wire logic [7:0] sfrWdata,
    input wire logic sfrRead,
    input wire logic [7:0] sfrRdata,
    input wire logic timer1Overflow,
    input wire logic timer0Overflow,
    input wire logic timer0Vector,
    input wire logic timer0CountEn,
    input wire logic timer1CountEn,
    input wire logic timer0CountSrcPin,
    input wire logic timer1CountSrcPin,
    input wire timer_regs_pkg::timer_mode_t timer0Mode,
    input wire timer_regs_pkg::timer_mode_t timer1Mode,
    input wire logic timer0CountTick
);
    import timer_regs_pkg::*;
    default clocking dc @(posedge clock); endclocking
    default disable iff (!rstn);
    // Reads that hit the two mapped registers, and writes to the mode register
    sequence ctrlRead;
        sfrRead && sfrAddr == 8'h88;
    endsequence
    sequence modeRead;
        sfrRead && sfrAddr == 8'h89;
    endsequence
    sequence modeWrite;
        sfrWrite && sfrAddr == 8'h89;
    endsequence
    chk_mode_output_follow: assert property (modeWrite |=> ##1
        timer0Mode == $past(sfrWdata[1:0], 2) &&
        timer1Mode == $past(sfrWdata[5:4], 2))
        else $error("mode outputs do not follow write");
    chk_idle_rdata_zero: assert property (
        !(sfrRead && (sfrAddr == 8'h88 || sfrAddr == 8'h89))
        |=> sfrRdata == 8'h00) else $error("read data not zero");
    chk_mode_read_match: assert property (modeRead |=>
        sfrRdata[1:0] == timer0Mode && sfrRdata[5:4] == timer1Mode &&
        sfrRdata[2] == timer0CountSrcPin && sfrRdata[6] == timer1CountSrcPin)
        else $error("mode read differs from outputs");
    chk_ovf_sets_flag: assert property (
        timer1Overflow ##1 ctrlRead |=> sfrRdata[7])
        else $error("overflow did not set flag");
    chk_vector_clears_flag: assert property (
        timer0Vector && !timer0Overflow ##1 ctrlRead |=> !sfrRdata[5])
        else $error("vector did not clear flag");
    chk_tick_needs_enable: assert property (
        timer0CountTick |-> timer0CountEn) else $error("tick while off");
    chk_timer_ticks_always: assert property (
        timer0CountEn && !timer0CountSrcPin |-> timer0CountTick)
        else $error("timer mode missed a tick");
    chk_timer1_mode_stop: assert property (
        timer1Mode == MODE_SPLIT |-> !timer1CountEn)
        else $error("timer1 runs in mode three");
endmodule : timer_regs_checker
bind timer_control_mode_regs timer_regs_checker ck (.clock, .rstn,
    .sfrAddr, .sfrWrite, .sfrWdata, .sfrRead, .sfrRdata, .timer1Overflow,
    .timer0Overflow, .timer0Vector, .timer0CountEn, .timer1CountEn,
    .timer0CountSrcPin, .timer1CountSrcPin, .timer0Mode, .timer1Mode,
    .timer0CountTick);
